// ### logic/bbs_exec.v
// Execution unit for conditional and unconditional relative branch and file bit-set.
`timescale 1ns/10ps
`default_nettype none
`include "bbs_exec_map.vh"

module bbs_exec #(
  parameter PCW = 21,
  parameter DAW = 12
) (
  // Clock and reset.
  input  wire              core_clk,
  input  wire              rst,
  // Instruction issue from fetch.
  input  wire              instr_valid,
  input  wire [15:0]       instr_word,
  output wire              instr_ready,
  // Data memory port.
  output reg  [DAW-1:0]    dmem_addr,
  output reg               dmem_re,
  output reg               dmem_we,
  output reg  [7:0]        dmem_wdata,
  input  wire [7:0]        dmem_rdata,
  // Program counter and phase.
  output reg  [PCW-1:0]    pc,
  output reg  [1:0]        q_phase,
  // AHB-Lite slave.
  input  wire              hsel,
  input  wire [7:0]        haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output reg  [31:0]       hrdata
);

  // Decode and execution state.
  reg  [15:0]     ir;
  reg             ir_live;
  reg             nop_cycle;
  reg             last_taken;
  reg             last_bset;
  reg  [7:0]      rmw_data;
  reg  [1:0]      ctrl;
  reg  [3:0]      bank_select_reg;
  reg  [DAW-1:0]  index_base;

  // Bus data-phase capture.
  reg             wr_pend;
  reg  [7:0]      wr_addr;

  // The step is sized to the counter so the increment drops no bits.
  localparam [PCW-1:0] PC_INC = `BBS_PC_STEP;

  wire            zero_flag = ctrl[`BBS_CTRL_ZERO];
  wire            ext_en    = ctrl[`BBS_CTRL_EXT];

  // Instruction classes.
  wire is_branch_if_zero_clear = (ir[15:8] == `BBS_OP_BNZ);
  wire is_relative_jump_always = (ir[15:11] == `BBS_OP_BRA);
  wire is_file_bit_set_op      = (ir[15:12] == `BBS_OP_BSF);

  wire take_cond = is_branch_if_zero_clear && !zero_flag;
  wire take_jump = take_cond || is_relative_jump_always;

  // Offsets, doubled and sign extended to the counter width.
  wire [PCW-1:0] off8  = {{(PCW-9){ir[7]}}, ir[7:0], 1'b0};
  wire [PCW-1:0] off11 = {{(PCW-12){ir[10]}}, ir[10:0], 1'b0};
  wire [PCW-1:0] jump_target = pc + (is_relative_jump_always ? off11 : off8);

  // File operand address mapping.
  wire [7:0] f_addr  = ir[`BBS_F_HI:0];
  wire       a_bit   = ir[`BBS_A_BIT];
  wire [2:0] bit_idx = ir[`BBS_B_HI:`BBS_B_LO];
  wire [7:0] split   = ext_en ? `BBS_SPLIT_EXT : `BBS_SPLIT_STD;
  reg  [DAW-1:0] file_addr;

  always @* begin
    if (a_bit) begin
      file_addr = {bank_select_reg, f_addr};
    end else if (ext_en && (f_addr <= `BBS_IDX_LIMIT)) begin
      file_addr = index_base + {4'h0, f_addr};
    end else if (f_addr < split) begin
      file_addr = {`BBS_LOW_BANK, f_addr};
    end else begin
      file_addr = {`BBS_SFR_BANK, f_addr};
    end
  end

  // Bit mask for the set operation; a loop keeps it one line per bit.
  wire [7:0] bit_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      assign bit_mask[gi] = (bit_idx == gi);
    end
  endgenerate

  // A new word is taken only at Q1 of a cycle that is not a flush NOP.
  assign instr_ready = (q_phase == `BBS_Q1) && !nop_cycle;
  wire   take_instr  = instr_ready && instr_valid;

  // Bus signalling: zero wait state, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  wire   bus_go    = hsel && hready && htrans[1];

  // Four-phase sequencer and execution.
  always @(posedge core_clk) begin
    if (rst) begin
      q_phase    <= `BBS_Q1;
      ir         <= 16'h0000;
      ir_live    <= 1'b0;
      nop_cycle  <= 1'b0;
      last_taken <= 1'b0;
      last_bset  <= 1'b0;
      rmw_data   <= 8'h00;
      dmem_addr  <= {DAW{1'b0}};
      dmem_re    <= 1'b0;
      dmem_we    <= 1'b0;
      dmem_wdata <= 8'h00;
      pc         <= {PCW{1'b0}};
    end else begin
      q_phase <= q_phase + 2'h1;
      dmem_re <= 1'b0;
      dmem_we <= 1'b0;
      case (q_phase)
        `BBS_Q1: begin
          if (take_instr) begin
            // The counter already points past the word when decode starts.
            ir      <= instr_word;
            ir_live <= 1'b1;
            pc      <= pc + PC_INC;
          end else begin
            ir_live <= 1'b0;
          end
        end
        `BBS_Q2: begin
          if (ir_live && is_file_bit_set_op) begin
            dmem_addr <= file_addr;
            dmem_re   <= 1'b1;
          end
        end
        `BBS_Q3: begin
          if (ir_live && is_file_bit_set_op) begin
            rmw_data <= dmem_rdata | bit_mask;
          end
        end
        `BBS_Q4: begin
          nop_cycle <= 1'b0;
          if (ir_live) begin
            last_taken <= take_jump;
            last_bset  <= is_file_bit_set_op;
            if (take_jump) begin
              pc        <= jump_target;
              nop_cycle <= 1'b1;
            end
            if (is_file_bit_set_op) begin
              dmem_we    <= 1'b1;
              dmem_wdata <= rmw_data;
            end
          end
        end
        default: begin
          nop_cycle <= 1'b0;
        end
      endcase
    end
  end

  // Register writes in the data phase. Flags are left alone by execution.
  always @(posedge core_clk) begin
    if (rst) begin
      wr_pend         <= 1'b0;
      wr_addr         <= 8'h00;
      ctrl            <= `BBS_RST_CTRL;
      bank_select_reg <= `BBS_RST_BANK;
      index_base      <= {DAW{1'b0}};
    end else begin
      wr_pend <= bus_go && hwrite;
      if (bus_go) begin
        wr_addr <= haddr;
      end
      if (wr_pend) begin
        case (wr_addr)
          `BBS_REG_CTRL:  ctrl            <= hwdata[1:0];
          `BBS_REG_BANK:  bank_select_reg <= hwdata[3:0];
          `BBS_REG_INDEX: index_base      <= hwdata[DAW-1:0];
          default:        ctrl            <= ctrl;
        endcase
      end
    end
  end

  // Read data is prepared at the address phase so it stands in the data phase.
  // A read right after a write to the same register sees the old value.
  always @(posedge core_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_go && !hwrite) begin
      case (haddr)
        `BBS_REG_CTRL:   hrdata <= {30'h0000_0000, ctrl};
        `BBS_REG_BANK:   hrdata <= {28'h000_0000, bank_select_reg};
        `BBS_REG_PC:     hrdata <= {{(32-PCW){1'b0}}, pc};
        `BBS_REG_INDEX:  hrdata <= {{(32-DAW){1'b0}}, index_base};
        `BBS_REG_STATUS: hrdata <= {26'h000_0000, last_bset, last_taken,
                                    ir_live, nop_cycle, q_phase};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // bbs_exec

`default_nettype wire

// ### logic/bbs_exec_map.vh
// Register offsets, opcode patterns and field positions of the branch and bit-set unit.
`ifndef BBS_EXEC_MAP_VH
`define BBS_EXEC_MAP_VH

// Register byte offsets on the bus.
`define BBS_REG_CTRL      8'h00
`define BBS_REG_BANK      8'h04
`define BBS_REG_PC        8'h08
`define BBS_REG_INDEX     8'h0C
`define BBS_REG_STATUS    8'h10

// Control register fields.
`define BBS_CTRL_ZERO     0
`define BBS_CTRL_EXT      1

// Status register fields.
`define BBS_ST_PHASE_LO   0
`define BBS_ST_PHASE_HI   1
`define BBS_ST_NOP        2
`define BBS_ST_BUSY       3
`define BBS_ST_TAKEN      4
`define BBS_ST_BSET       5

// Reset values.
`define BBS_RST_CTRL      2'h0
`define BBS_RST_BANK      4'h0

// Four phases of one instruction cycle.
`define BBS_Q1            2'h0
`define BBS_Q2            2'h1
`define BBS_Q3            2'h2
`define BBS_Q4            2'h3

// Opcode patterns.
`define BBS_OP_BNZ        8'hE1
`define BBS_OP_BRA        5'h1A
`define BBS_OP_BSF        4'h8

// Instruction word fields.
`define BBS_F_HI          7
`define BBS_B_LO          9
`define BBS_B_HI          11
`define BBS_A_BIT         8

// Access-bank layout.
`define BBS_IDX_LIMIT     8'h5F
`define BBS_SPLIT_EXT     8'h60
`define BBS_SPLIT_STD     8'h80
`define BBS_SFR_BANK      4'hF
`define BBS_LOW_BANK      4'h0

// Program counter step per instruction word.
`define BBS_PC_STEP       2

`endif

// ### dv/bbs_exec_chk.sv
// Port-level assertions for the branch and bit-set unit.
`timescale 1ns/10ps
`default_nettype none
module bbs_exec_chk #(
  parameter PCW = 21,
  parameter DAW = 12
) (
  // Clock and reset.
  input wire logic           core_clk,
  input wire logic           rst,
  // Instruction issue.
  input wire logic           instr_valid,
  input wire logic [15:0]    instr_word,
  input wire logic           instr_ready,
  // Data memory and program counter.
  input wire logic           dmem_re,
  input wire logic           dmem_we,
  input wire logic [7:0]     dmem_wdata,
  input wire logic [7:0]     dmem_rdata,
  input wire logic [PCW-1:0] pc,
  input wire logic [1:0]     q_phase
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  localparam [PCW-1:0] TWO = 2;
  wire           take   = instr_valid && instr_ready;
  wire           is_bnz = take && instr_word[15:8] == 8'hE1;
  wire           is_bra = take && instr_word[15:11] == 5'h1A;
  wire           is_bsf = take && instr_word[15:12] == 4'h8;
  wire [2:0]     bit_ix = instr_word[11:9];
  wire [PCW-1:0] off_b  = {{(PCW-9){instr_word[7]}}, instr_word[7:0], 1'b0};
  wire [PCW-1:0] off_j  = {{(PCW-12){instr_word[10]}}, instr_word[10:0], 1'b0};

  chk_phase_step: assert property ($past(!rst) |-> q_phase == $past(q_phase) + 2'h1)
    else $error("phase did not advance");
  chk_bnz_target: assert property (is_bnz |-> ##4 (instr_ready ?
    pc == $past(pc, 4) + TWO : pc == $past(pc, 4) + TWO + $past(off_b, 4)))
    else $error("bad branch target");
  chk_bnz_cycles: assert property (is_bnz && instr_word[7:0] != 8'h00 |->
    ##4 (instr_ready == (pc == $past(pc, 4) + TWO))) else $error("bad branch length");
  chk_bra_target: assert property (is_bra |-> ##4
    pc == $past(pc, 4) + TWO + $past(off_j, 4)) else $error("bad jump target");
  chk_bra_stall: assert property (is_bra |-> ##4 !instr_ready ##4 instr_ready)
    else $error("jump not two cycles");
  chk_bset_write: assert property (is_bsf |-> ##4 dmem_we)
    else $error("bit-set write missing");
  chk_read_phase: assert property (dmem_re |-> q_phase == 2'h2)
    else $error("read outside its phase");
  chk_write_phase: assert property (dmem_we |-> q_phase == 2'h0 && $past(dmem_re, 2))
    else $error("write not after read");
  chk_rmw_data: assert property (dmem_we |-> dmem_wdata ==
    ($past(dmem_rdata, 2) | (8'h01 << $past(bit_ix, 4)))) else $error("bad set data");
  cover property (is_bnz);
  cover property (is_bra);
  cover property (dmem_we);
endmodule // bbs_exec_chk

bind bbs_exec bbs_exec_chk #(.PCW(PCW), .DAW(DAW)) u_chk (.core_clk(core_clk), .rst(rst),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
  .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
  .dmem_rdata(dmem_rdata), .pc(pc), .q_phase(q_phase));
`default_nettype wire

// ### dv/bbs_exec_tb.sv
// Self-checking bench for the branch and bit-set unit.
`timescale 1ns/10ps
`default_nettype none
module bbs_exec_tb;
  logic        core_clk = 0, rst = 1, instr_valid = 0, hsel = 1, hwrite = 0, z;
  logic [15:0] instr_word = 0;
  logic [7:0]  haddr = 0, dmem_rdata, n, f, d;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, b;
  logic [31:0] hwdata = 0, rd;
  logic [10:0] m;
  logic [3:0]  bank;
  logic [11:0] idx, ea;
  logic [20:0] exp_pc = 0;
  logic [7:0]  mem [0:4095];
  integer      miscompares = 0, comparisons = 0, cyc = 0, i;
  wire         instr_ready, dmem_re, dmem_we, hreadyout, hresp;
  wire  [11:0] dmem_addr;
  wire  [7:0]  dmem_wdata;
  wire  [20:0] pc;
  wire  [1:0]  q_phase;
  wire  [31:0] hrdata;

  bbs_exec DUT (.core_clk, .rst, .instr_valid, .instr_word, .instr_ready, .dmem_addr,
    .dmem_re, .dmem_we, .dmem_wdata, .dmem_rdata, .pc, .q_phase, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);

  always #5 core_clk = ~core_clk;
  // The memory answers at once, so read data stands in the read phase.
  always @* dmem_rdata = mem[dmem_addr];
  always @(posedge core_clk) if (dmem_we) mem[dmem_addr] <= dmem_wdata;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic issue(input logic [15:0] w);
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(posedge core_clk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    exp_pc = exp_pc + 21'h2;
    repeat (8) @(posedge core_clk);
  endtask

  function automatic logic [11:0] eaddr(input logic a, input logic x, input logic [7:0] fa,
                                        input logic [3:0] bk, input logic [11:0] ix);
    if (a) return {bk, fa};
    if (x && fa <= 8'h5F) return ix + fa;
    return (fa < (x ? 8'h60 : 8'h80)) ? {4'h0, fa} : {4'hF, fa};
  endfunction

  initial begin
    i = $urandom(32'he4d25b4f);
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    bus(0, 8'h00, 0);
    check(rd, 0);
    bus(0, 8'h04, 0);
    check(rd, 0);
    for (i = 0; i < 8; i++) begin
      z = i[1];
      n = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
      bus(1, 8'h00, {31'h0, z});
      issue({8'hE1, n});
      if (!z) exp_pc = exp_pc + {{12{n[7]}}, n, 1'b0};
      check(pc, exp_pc);
      m = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : 11'($urandom);
      issue({5'h1A, m});
      exp_pc = exp_pc + {{9{m[10]}}, m, 1'b0};
      check(pc, exp_pc);
    end
    bus(0, 8'h08, 0);
    check(rd, {11'h0, exp_pc});
    bus(0, 8'h14, 0);
    check(rd, 0);
    for (i = 0; i < 16; i++) begin
      f = (i == 2) ? 8'h5F : (i == 6) ? 8'h60 : (i == 4) ? 8'h7F : (i == 8) ? 8'h80 : 8'($urandom);
      b = 3'($urandom);
      bank = 4'($urandom);
      idx = 12'($urandom);
      d = 8'($urandom);
      bus(1, 8'h00, {30'h0, i[1], 1'b0});
      bus(1, 8'h04, {28'h0, bank});
      bus(1, 8'h0C, {20'h0, idx});
      bus(0, 8'h04, 0);
      check(rd, {28'h0, bank});
      ea = eaddr(i[0], i[1], f, bank, idx);
      mem[ea] = d;
      issue({4'h8, b, i[0], f});
      check(mem[ea], d | (8'h01 << b));
    end
    check(pc, exp_pc);
    end_sim;
  end

  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule // bbs_exec_tb
`default_nettype wire
